/* verilog/nmsc_consts.svh */
// constants of the network monitor statistic counter bank
`ifndef NMSC_CONSTS_SVH
`define NMSC_CONSTS_SVH
`define NMSC_NUM_CNT       21
`define NMSC_OFS_COLL      32'h0000_0100
`define NMSC_OFS_TX_OCT    32'h0000_0104
`define NMSC_OFS_TX_PKT    32'h0000_0108
`define NMSC_OFS_TX_64     32'h0000_010c
`define NMSC_OFS_TX_65     32'h0000_0110
`define NMSC_OFS_TX_128    32'h0000_0114
`define NMSC_OFS_TX_256    32'h0000_0118
`define NMSC_OFS_TX_512    32'h0000_011c
`define NMSC_OFS_TX_1024   32'h0000_0120
`define NMSC_OFS_CRC_ALIGN 32'h0000_0124
`define NMSC_OFS_UNDERSIZE 32'h0000_0128
`define NMSC_OFS_FRAG      32'h0000_012c
`define NMSC_OFS_JABBER    32'h0000_0130
`define NMSC_OFS_RX_OCT    32'h0000_0134
`define NMSC_OFS_RX_PKT    32'h0000_0138
`define NMSC_OFS_RX_64     32'h0000_013c
`define NMSC_OFS_RX_65     32'h0000_0140
`define NMSC_OFS_RX_128    32'h0000_0144
`define NMSC_OFS_RX_256    32'h0000_0148
`define NMSC_OFS_RX_512    32'h0000_014c
`define NMSC_OFS_RX_1024   32'h0000_0150
`define NMSC_IX(o)         (((o) - `NMSC_OFS_COLL) >> 2)
`define NMSC_CNT_RST       32'h0000_0000
`define NMSC_THRESHOLD     32'h0000_c000
`define NMSC_LEN_64        16'h0040
`define NMSC_LEN_127       16'h007f
`define NMSC_LEN_255       16'h00ff
`define NMSC_LEN_511       16'h01ff
`define NMSC_LEN_1023      16'h03ff
`define NMSC_LEN_1518      16'h05ee
`define NMSC_VLAN_OCTETS   16'h0004
`define NMSC_PAT_END       8'h00
`define NMSC_NIB_EXT       4'hf
`define NMSC_CRC_LAST      2'h3
`endif

/* verilog/nmsc_pkg.sv */
// types of the network monitor statistic counter bank
package nmsc_pkg;
  typedef enum logic [1:0] {
    nmsc_st_pat     = 2'b00,
    nmsc_st_ext_off = 2'b01,
    nmsc_st_ext_cnt = 2'b10,
    nmsc_st_crc     = 2'b11
  } nmsc_parse_e;
  typedef logic [31:0] nmsc_word_t;
  typedef logic [15:0] nmsc_len_t;
endpackage

/* verilog/nmsc_cnt_if.sv */
// carrier between the bank controller and the counter storage
`timescale 1ns/1ps
interface nmsc_cnt_if import nmsc_pkg::*; #(parameter int N = 21);
  logic [N-1:0]         inc_en;
  nmsc_len_t            inc_val [N];
  logic                 wr_en;
  logic [$clog2(N)-1:0] idx;
  nmsc_word_t           wdata;
  nmsc_word_t           rdata;
  logic [N-1:0]         thr_hit;
  modport ctl  (output inc_en, inc_val, wr_en, idx, wdata, input rdata, thr_hit);
  modport bank (input inc_en, inc_val, wr_en, idx, wdata, output rdata, thr_hit);
endinterface

/* verilog/nmsc_cnt_bank.sv */
// storage of the statistic counters with registered read data
`timescale 1ns/1ps
`include "nmsc_consts.svh"
module nmsc_cnt_bank import nmsc_pkg::*; #(
  parameter int N = 21
) (
  input wire logic core_clk,
  input wire logic nrst,
  nmsc_cnt_if.bank cb
);
  localparam int IW = $clog2(N);
  nmsc_word_t   cnt [N];
  logic [N-1:0] next_thr_hit;
  nmsc_word_t   next_rdata;

  for (genvar i = 0; i < N; i++) begin : g_cnt
    wire nmsc_word_t sum  = cnt[i] + {16'h0000, cb.inc_val[i]};
    wire logic       wr_i = cb.wr_en && (cb.idx == IW'(i));
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        cnt[i] <= `NMSC_CNT_RST;
      end else if (wr_i) begin
        cnt[i] <= cb.wdata;
      end else if (cb.inc_en[i]) begin
        cnt[i] <= sum;
      end
    end
    // crossing of the threshold by counting, not by a host write
    assign next_thr_hit[i] = !wr_i && cb.inc_en[i] &&
                             (cnt[i] < `NMSC_THRESHOLD) && (sum >= `NMSC_THRESHOLD);
  end

  assign next_rdata = (cb.idx < IW'(N)) ? cnt[cb.idx] : `NMSC_CNT_RST;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cb.rdata   <= `NMSC_CNT_RST;
      cb.thr_hit <= '0;
    end else begin
      cb.rdata   <= next_rdata;
      cb.thr_hit <= next_thr_hit;
    end
  end
endmodule

/* verilog/nmsc_wake_parse.sv */
// parser of wake pattern entries, terminator and reference crc
`timescale 1ns/1ps
`include "nmsc_consts.svh"
module nmsc_wake_parse import nmsc_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_in,
  output logic             entry_valid,
  output logic [7:0]       entry_offset,
  output logic [7:0]       entry_count,
  output logic             crc_valid,
  output logic [31:0]      ref_crc
);
  nmsc_parse_e state;
  logic [7:0]  hold;
  logic        cnt_ext;
  logic [1:0]  crc_n;
  logic [31:0] crc_sh;
  wire  [3:0]  nib_off = byte_in[7:4];
  wire  [3:0]  nib_cnt = byte_in[3:0];
  wire  [31:0] next_crc_sh = {byte_in, crc_sh[31:8]};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state        <= nmsc_st_pat;
      hold         <= 8'h00;
      cnt_ext      <= 1'b0;
      crc_n        <= 2'h0;
      crc_sh       <= 32'h0000_0000;
      entry_valid  <= 1'b0;
      entry_offset <= 8'h00;
      entry_count  <= 8'h00;
      crc_valid    <= 1'b0;
      ref_crc      <= 32'h0000_0000;
    end else begin
      entry_valid <= 1'b0;
      crc_valid   <= 1'b0;
      if (byte_valid) begin
        unique case (state)
          nmsc_st_pat: begin
            if (byte_in == `NMSC_PAT_END) begin
              state <= nmsc_st_crc;
              crc_n <= 2'h0;
            end else if (nib_off == `NMSC_NIB_EXT) begin
              hold    <= {4'h0, nib_cnt};
              cnt_ext <= (nib_cnt == `NMSC_NIB_EXT);
              state   <= nmsc_st_ext_off;
            end else if (nib_cnt == `NMSC_NIB_EXT) begin
              hold  <= {4'h0, nib_off};
              state <= nmsc_st_ext_cnt;
            end else begin
              entry_valid  <= 1'b1;
              entry_offset <= {4'h0, nib_off};
              entry_count  <= {4'h0, nib_cnt};
            end
          end
          nmsc_st_ext_off: begin
            if (cnt_ext) begin
              hold  <= byte_in;
              state <= nmsc_st_ext_cnt;
            end else begin
              entry_valid  <= 1'b1;
              entry_offset <= byte_in;
              entry_count  <= hold;
              state        <= nmsc_st_pat;
            end
          end
          nmsc_st_ext_cnt: begin
            entry_valid  <= 1'b1;
            entry_offset <= hold;
            entry_count  <= byte_in;
            state        <= nmsc_st_pat;
          end
          nmsc_st_crc: begin
            // least significant crc byte first
            crc_sh <= next_crc_sh;
            crc_n  <= crc_n + 2'h1;
            if (crc_n == `NMSC_CRC_LAST) begin
              crc_valid <= 1'b1;
              ref_crc   <= next_crc_sh;
              state     <= nmsc_st_pat;
            end
          end
        endcase
      end
    end
  end
endmodule

/* verilog/nmsc_top.sv */
// network monitor statistic counter bank with memory-mapped access
`timescale 1ns/1ps
`include "nmsc_consts.svh"
module nmsc_top import nmsc_pkg::*; #(
  parameter int N = `NMSC_NUM_CNT
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         mem_space,
  input  wire logic         io_space,
  input  wire logic [31:0]  acc_addr,
  input  wire logic         acc_wr,
  input  wire logic         acc_rd,
  input  wire logic [31:0]  acc_wdata,
  input  wire logic [31:0]  memory_window_base,
  output logic [31:0]       acc_rdata,
  output logic              acc_ack,
  input  wire logic         stats_global_enable,
  input  wire logic [N-1:0] monitor_count_mask,
  input  wire logic         collision_evt,
  input  wire logic         rx_done,
  input  wire logic [15:0]  rx_len,
  input  wire logic         rx_fcs_bad,
  input  wire logic         rx_vlan_stripped,
  input  wire logic         tx_done,
  input  wire logic [15:0]  tx_len,
  input  wire logic         tx_vlan_inserted,
  output logic              stats_threshold_flag,
  input  wire logic         wake_byte_valid,
  input  wire logic [7:0]   wake_byte,
  output logic              wake_entry_valid,
  output logic [7:0]        wake_entry_offset,
  output logic [7:0]        wake_entry_count,
  output logic              wake_crc_valid,
  output logic [31:0]       wake_ref_crc
);
  localparam int IW = $clog2(N);

  nmsc_cnt_if #(.N(N)) cb ();

  // ---- access decode
  wire nmsc_word_t off = acc_addr - memory_window_base;
  // i/o-space strobes are never decoded here
  wire logic in_win = mem_space && (off >= `NMSC_OFS_COLL)
                      && (off <= `NMSC_OFS_RX_1024) && (off[1:0] == 2'b00);
  wire logic io_only  = io_space && !mem_space;
  wire logic take_wr  = in_win && acc_wr && !io_only;
  wire logic take_rd  = in_win && acc_rd && !acc_wr && !io_only;
  wire logic take_any = take_wr || take_rd;
  wire nmsc_word_t ix_full = `NMSC_IX(off);
  wire logic [IW-1:0] ix = ix_full[IW-1:0];

  logic ack_p1;
  logic rd_p1;
  logic next_flag;

  // ---- lengths on the wire including a stripped or inserted tag
  wire nmsc_len_t rx_tag = rx_vlan_stripped ? `NMSC_VLAN_OCTETS : 16'h0000;
  wire nmsc_len_t tx_tag = tx_vlan_inserted ? `NMSC_VLAN_OCTETS : 16'h0000;
  // incoming lengths already omit preamble and delimiter and hold the fcs
  wire nmsc_len_t rx_wlen = rx_len + rx_tag;
  wire nmsc_len_t tx_wlen = tx_len + tx_tag;

  // ---- length classes
  function automatic logic [5:0] bin_of(input nmsc_len_t l);
    logic [5:0] b;
    b    = 6'h00;
    b[0] = (l == `NMSC_LEN_64);
    b[1] = (l > `NMSC_LEN_64) && (l <= `NMSC_LEN_127);
    b[2] = (l > `NMSC_LEN_127) && (l <= `NMSC_LEN_255);
    b[3] = (l > `NMSC_LEN_255) && (l <= `NMSC_LEN_511);
    b[4] = (l > `NMSC_LEN_511) && (l <= `NMSC_LEN_1023);
    b[5] = (l > `NMSC_LEN_1023) && (l <= `NMSC_LEN_1518);
    return b;
  endfunction

  wire logic [5:0] rx_bin = bin_of(rx_wlen);
  wire logic [5:0] tx_bin = bin_of(tx_wlen);
  wire logic rx_short = rx_wlen < `NMSC_LEN_64;
  wire logic rx_long  = rx_wlen > `NMSC_LEN_1518;
  wire logic rx_norm  = !rx_short && !rx_long;

  // ---- raw events per counter index
  logic [N-1:0] ev;
  assign ev[`NMSC_IX(`NMSC_OFS_COLL)]      = collision_evt;
  assign ev[`NMSC_IX(`NMSC_OFS_TX_OCT)]    = tx_done;
  assign ev[`NMSC_IX(`NMSC_OFS_TX_PKT)]    = tx_done;
  assign ev[`NMSC_IX(`NMSC_OFS_TX_64)]     = tx_done && tx_bin[0];
  assign ev[`NMSC_IX(`NMSC_OFS_TX_65)]     = tx_done && tx_bin[1];
  assign ev[`NMSC_IX(`NMSC_OFS_TX_128)]    = tx_done && tx_bin[2];
  assign ev[`NMSC_IX(`NMSC_OFS_TX_256)]    = tx_done && tx_bin[3];
  assign ev[`NMSC_IX(`NMSC_OFS_TX_512)]    = tx_done && tx_bin[4];
  assign ev[`NMSC_IX(`NMSC_OFS_TX_1024)]   = tx_done && tx_bin[5];
  assign ev[`NMSC_IX(`NMSC_OFS_CRC_ALIGN)] = rx_done && rx_fcs_bad && rx_norm;
  assign ev[`NMSC_IX(`NMSC_OFS_UNDERSIZE)] = rx_done && !rx_fcs_bad && rx_short;
  assign ev[`NMSC_IX(`NMSC_OFS_FRAG)]      = rx_done && rx_fcs_bad && rx_short;
  assign ev[`NMSC_IX(`NMSC_OFS_JABBER)]    = rx_done && rx_fcs_bad && rx_long;
  assign ev[`NMSC_IX(`NMSC_OFS_RX_OCT)]    = rx_done;
  assign ev[`NMSC_IX(`NMSC_OFS_RX_PKT)]    = rx_done;
  assign ev[`NMSC_IX(`NMSC_OFS_RX_64)]     = rx_done && rx_bin[0];
  assign ev[`NMSC_IX(`NMSC_OFS_RX_65)]     = rx_done && rx_bin[1];
  assign ev[`NMSC_IX(`NMSC_OFS_RX_128)]    = rx_done && rx_bin[2];
  assign ev[`NMSC_IX(`NMSC_OFS_RX_256)]    = rx_done && rx_bin[3];
  assign ev[`NMSC_IX(`NMSC_OFS_RX_512)]    = rx_done && rx_bin[4];
  assign ev[`NMSC_IX(`NMSC_OFS_RX_1024)]   = rx_done && rx_bin[5];

  // dropped, overlength, broadcast and multicast totals live in the mac
  // statistic block, so no storage is spent on them here

  // ---- gating and increment amounts
  wire logic [N-1:0] cnt_on = {N{stats_global_enable}} & ~monitor_count_mask;
  assign cb.inc_en = ev & cnt_on;

  for (genvar i = 0; i < N; i++) begin : g_inc
    if (i == `NMSC_IX(`NMSC_OFS_RX_OCT)) begin : g_rx_oct
      assign cb.inc_val[i] = rx_wlen;
    end else if (i == `NMSC_IX(`NMSC_OFS_TX_OCT)) begin : g_tx_oct
      assign cb.inc_val[i] = tx_wlen;
    end else begin : g_one
      assign cb.inc_val[i] = 16'h0001;
    end
  end

  // ---- host side of the bank
  assign cb.wr_en = take_wr;
  assign cb.idx   = ix;
  assign cb.wdata = acc_wdata;

  assign next_flag = |cb.thr_hit;

  nmsc_cnt_bank #(.N(N)) u_bank (
    .core_clk (core_clk),
    .nrst     (nrst),
    .cb       (cb)
  );

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_p1 <= 1'b0;
      rd_p1  <= 1'b0;
    end else begin
      ack_p1 <= take_any;
      rd_p1  <= take_rd;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_ack   <= 1'b0;
      acc_rdata <= 32'h0000_0000;
    end else begin
      acc_ack   <= ack_p1;
      acc_rdata <= rd_p1 ? cb.rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stats_threshold_flag <= 1'b0;
    end else begin
      stats_threshold_flag <= next_flag;
    end
  end

  nmsc_wake_parse u_wake (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .byte_valid   (wake_byte_valid),
    .byte_in      (wake_byte),
    .entry_valid  (wake_entry_valid),
    .entry_offset (wake_entry_offset),
    .entry_count  (wake_entry_count),
    .crc_valid    (wake_crc_valid),
    .ref_crc      (wake_ref_crc)
  );
endmodule

/* verif/nmsc_top_sva.sv */
// assertions on the ports of the statistic counter bank
`timescale 1ns/1ps
module nmsc_top_sva import nmsc_pkg::*; #(
  parameter int N = 21
) (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        mem_space,
  input wire logic        io_space,
  input wire logic [31:0] acc_addr,
  input wire logic        acc_wr,
  input wire logic        acc_rd,
  input wire logic [31:0] memory_window_base,
  input wire logic [31:0] acc_rdata,
  input wire logic        acc_ack,
  input wire logic        stats_global_enable,
  input wire logic        collision_evt,
  input wire logic        rx_done,
  input wire logic        tx_done,
  input wire logic        stats_threshold_flag,
  input wire logic        wake_byte_valid,
  input wire logic        wake_entry_valid,
  input wire logic        wake_crc_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire logic [31:0] ofs  = acc_addr - memory_window_base;
  wire logic        req  = acc_wr | acc_rd;
  wire logic        inwin = (ofs >= 32'h100) && (ofs <= 32'h150) && (ofs[1:0] == 2'h0);
  wire logic        take = mem_space & req & inwin;
  wire logic        evt  = stats_global_enable & (rx_done | tx_done | collision_evt);
  sequence s_answer;
    ##2 acc_ack;
  endsequence
  sequence s_silent;
    ##2 !acc_ack;
  endsequence
  a_ack_two_cycles: assert property (take |-> s_answer)
    else $error("access not answered two cycles later");
  a_ack_has_cause: assert property (acc_ack |-> $past(take, 2))
    else $error("answer without a taken access");
  a_io_refused: assert property (io_space && !mem_space && req |-> s_silent)
    else $error("i/o space access answered");
  a_window_refused: assert property (mem_space && req && !inwin |-> s_silent)
    else $error("access outside the counter window answered");
  a_rdata_idle: assert property (!acc_ack |-> acc_rdata == 32'h0)
    else $error("read data not zero outside an answer");
  a_flag_has_event: assert property (stats_threshold_flag |-> $past(evt, 2))
    else $error("threshold flag without an enabled event");
  a_entry_has_byte: assert property (wake_entry_valid |-> $past(wake_byte_valid))
    else $error("pattern entry without a byte");
  a_crc_has_byte: assert property (wake_crc_valid |-> $past(wake_byte_valid) && !wake_entry_valid)
    else $error("reference crc without a byte");
endmodule
bind nmsc_top nmsc_top_sva #(.N(N)) nmsc_top_sva_i (
  .core_clk, .nrst, .mem_space, .io_space, .acc_addr, .acc_wr, .acc_rd,
  .memory_window_base, .acc_rdata, .acc_ack, .stats_global_enable,
  .collision_evt, .rx_done, .tx_done, .stats_threshold_flag,
  .wake_byte_valid, .wake_entry_valid, .wake_crc_valid
);

/* verif/test_nmsc_top.sv */
// self-checking bench of the statistic counter bank
`timescale 1ns/1ps
module test_nmsc_top import nmsc_pkg::*;;
  logic core_clk = 1'b0;
  logic nrst, mem_space, io_space, acc_wr, acc_rd, acc_ack, stats_global_enable;
  logic collision_evt, rx_done, rx_fcs_bad, rx_vlan_stripped, tx_done, tx_vlan_inserted;
  logic wake_byte_valid, wake_entry_valid, wake_crc_valid, stats_threshold_flag;
  logic [31:0] acc_addr, acc_wdata, memory_window_base, acc_rdata, wake_ref_crc;
  logic [20:0] monitor_count_mask;
  logic [15:0] rx_len, tx_len;
  logic [7:0]  wake_byte, wake_entry_offset, wake_entry_count;
  logic [31:0] seed = 32'h0179;
  nmsc_word_t  exp [21];
  logic [15:0] ent_q [$];
  logic [31:0] crc_q [$];
  logic [15:0] corner [14] = '{63, 64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1518,
                               1519, 60};
  logic [7:0]  wb [13] = '{8'h23, 8'hf5, 8'h40, 8'hff, 8'h11, 8'h22, 8'h3f, 8'h07, 8'h00,
                           8'h78, 8'h56, 8'h34, 8'h12};
  logic [31:0] bad_ofs [4] = '{32'h0fc, 32'h154, 32'h102, 32'h100};
  int fail_count = 0, checks_done = 0, cycles = 0, flags_seen = 0, exp_flags = 0;

  nmsc_top #(.N(21)) nmsc_top_i (
    .core_clk, .nrst, .mem_space, .io_space, .acc_addr, .acc_wr, .acc_rd, .acc_wdata,
    .memory_window_base, .acc_rdata, .acc_ack, .stats_global_enable, .monitor_count_mask,
    .collision_evt, .rx_done, .rx_len, .rx_fcs_bad, .rx_vlan_stripped, .tx_done, .tx_len,
    .tx_vlan_inserted, .stats_threshold_flag, .wake_byte_valid, .wake_byte,
    .wake_entry_valid, .wake_entry_offset, .wake_entry_count, .wake_crc_valid, .wake_ref_crc
  );

  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (stats_threshold_flag === 1'b1) flags_seen++;
    if (wake_entry_valid === 1'b1) ent_q.push_back({wake_entry_offset, wake_entry_count});
    if (wake_crc_valid === 1'b1) crc_q.push_back(wake_ref_crc);
    if (cycles == 20000) begin
      fail_count++;
      $display("unexpected at %0t: run did not complete", $time);
      finish_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic int bin(input logic [15:0] l);
    if (l < 16'd64 || l > 16'd1518) return -1;
    return (l == 16'd64) ? 0 : (l < 16'd128) ? 1 : (l < 16'd256) ? 2 :
           (l < 16'd512) ? 3 : (l < 16'd1024) ? 4 : 5;
  endfunction

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // one access, then watch three cycles for the answer
  task automatic acc(input logic wr, input logic [31:0] o, input nmsc_word_t d,
                     input logic io, output logic ack, output nmsc_word_t q);
    @(negedge core_clk);
    mem_space = !io;
    io_space = io;
    acc_addr = memory_window_base + o;
    acc_wr = wr;
    acc_rd = !wr;
    acc_wdata = d;
    @(negedge core_clk);
    {acc_wr, acc_rd, mem_space, io_space} = 4'h0;
    ack = 1'b0;
    q = '0;
    repeat (3) begin
      @(negedge core_clk);
      if (acc_ack === 1'b1) begin
        ack = 1'b1;
        q = acc_rdata;
      end
    end
  endtask

  task automatic wr_reg(input int i, input nmsc_word_t d);
    logic a;
    nmsc_word_t q;
    acc(1'b1, 32'h100 + 4 * i, d, 1'b0, a, q);
    chk(a === 1'b1, "write not answered");
    exp[i] = d;
  endtask

  task automatic rd_chk(input int i);
    logic a;
    nmsc_word_t q;
    acc(1'b0, 32'h100 + 4 * i, '0, 1'b0, a, q);
    chk(a === 1'b1 && q === exp[i], "counter read mismatch");
  endtask

  // kind 0 collision, 1 receive, 2 transmit; model updated alongside
  task automatic frame(input int k, input logic [15:0] len, input logic bad, input logic tag);
    nmsc_word_t inc [21];
    nmsc_word_t nv;
    logic [15:0] l;
    logic hit;
    int b;
    @(negedge core_clk);
    collision_evt = (k == 0);
    {rx_done, rx_len, rx_fcs_bad, rx_vlan_stripped} = {k == 1, len, bad, tag};
    {tx_done, tx_len, tx_vlan_inserted} = {k == 2, len, tag};
    foreach (inc[i]) inc[i] = '0;
    l = len + (tag ? 16'd4 : 16'd0);
    b = (k == 1) ? 13 : 1;
    if (k == 0) inc[0] = 32'h1;
    else begin
      inc[b] = {16'h0, l};
      inc[b + 1] = 32'h1;
      if (bin(l) >= 0) inc[((k == 1) ? 15 : 3) + bin(l)] = 32'h1;
      if (k == 1 && bad) inc[(l < 16'd64) ? 11 : (l <= 16'd1518) ? 9 : 12] = 32'h1;
      if (k == 1 && !bad && l < 16'd64) inc[10] = 32'h1;
    end
    hit = 1'b0;
    foreach (inc[i]) if (inc[i] != 0 && stats_global_enable && !monitor_count_mask[i]) begin
      nv = exp[i] + inc[i];
      if (exp[i] < 32'hc000 && nv >= 32'hc000) hit = 1'b1;
      exp[i] = nv;
    end
    exp_flags += hit;
    @(negedge core_clk);
    {collision_evt, rx_done, tx_done} = 3'h0;
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    logic a;
    nmsc_word_t q;
    {nrst, mem_space, io_space, acc_wr, acc_rd, collision_evt, rx_done} = '0;
    {rx_fcs_bad, rx_vlan_stripped, tx_done, tx_vlan_inserted, wake_byte_valid} = '0;
    {acc_addr, acc_wdata, rx_len, tx_len, wake_byte, monitor_count_mask} = '0;
    stats_global_enable = 1'b0;
    // nonzero base so the offset subtraction is exercised
    memory_window_base = (rnd() << 12) & 32'h7fff_f000;
    foreach (exp[i]) exp[i] = '0;
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    for (int i = 0; i < 21; i++) rd_chk(i);
    for (int i = 0; i < 21; i++) begin
      wr_reg(i, rnd());
      rd_chk(i);
      wr_reg(i, rnd() & 32'h0000_bfff);
    end
    wr_reg(0, 32'h0000_bfff);
    wr_reg(14, 32'h0000_bfff);
    foreach (bad_ofs[i]) begin
      acc(i[0], bad_ofs[i], rnd(), i == 3, a, q);
      chk(a === 1'b0, "refused access answered");
    end
    for (int n = 0; n < 60; n++) begin
      stats_global_enable = (n < 14) || (rnd() % 8 != 0);
      monitor_count_mask = (n < 14) ? '0 : 21'(rnd() & rnd() & rnd());
      // after the opening collision, corner lengths alternate between receive and transmit
      frame((n == 0) ? 0 : (n < 14) ? 1 + n % 2 : n % 3,
            (n < 14) ? corner[n] : 16'(20 + rnd() % 1580), rnd() % 2, n >= 13 && rnd() % 2);
    end
    stats_global_enable = 1'b1;
    monitor_count_mask = '0;
    for (int i = 0; i < 21; i++) rd_chk(i);
    chk(flags_seen == exp_flags, "threshold flag count");
    foreach (wb[i]) begin
      @(negedge core_clk);
      wake_byte_valid = 1'b1;
      wake_byte = wb[i];
      @(negedge core_clk);
      wake_byte_valid = 1'b0;
    end
    repeat (3) @(negedge core_clk);
    chk(ent_q.size() == 4 && ent_q[0] === 16'h0203 && ent_q[1] === 16'h4005
        && ent_q[2] === 16'h1122 && ent_q[3] === 16'h0307, "pattern entries");
    chk(crc_q.size() == 1 && crc_q[0] === 32'h1234_5678, "reference crc");
    finish_test();
  end
endmodule
